// ---- resonant_pwm_defines.svh ----
// Offsets, field positions, reset values and timing counts for the
// resonant PWM edge timing block. Assumes inclusion by bare name only.
`ifndef RESONANT_PWM_DEFINES_SVH
`define RESONANT_PWM_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index
`define SW_FREQ_IDX      8'h40
`define EDGE_TRIM7_IDX   8'h6F
`define PERIOD_IDX       8'h80
`define DEAD_IDX         8'h81
`define STATUS_IDX       8'h82

// Field positions
`define FREQ_FIELD_MSB   5
`define RESONANT_CODE    6'h3F
`define TRIM1_SIGN_BIT   7
`define TRIM1_MAG_LSB    4
`define TRIM2_SIGN_BIT   3
`define TRIM2_MAG_LSB    0

// Reset values
`define SW_FREQ_RST      8'h00
`define EDGE_TRIM7_RST   8'h00
`define PERIOD_RST       16'h00C8
`define DEAD_RST         16'h000A

// Timing: edges are counted in 5 ns ticks, the clock runs at 50 ns
`define CLK_PERIOD_NS    50
`define TICK_NS          5
`define TICKS_PER_CLK    (`CLK_PERIOD_NS / `TICK_NS)

// Bus answers
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ---- resonant_pwm_pkg.sv ----
// Types shared by the resonant PWM edge timing block.
// Assumes nothing of its surroundings.
`default_nettype none
package resonant_pwm_pkg;

  // One edge trim field: sign and magnitude in 5 ns ticks
  typedef struct packed {
    logic       neg;
    logic [2:0] mag;
  } edge_trim_t;

  // Which half of the switching cycle the counter is in
  typedef enum logic {
    HALF_FIRST  = 1'b0,
    HALF_SECOND = 1'b1
  } half_t;

endpackage
`default_nettype wire

// ---- resonant_pwm_edge_timing.sv ----
// Resonant-mode PWM generator: four drive outputs with two trimmed edges.
// Assumes an AXI4-Lite master on the one 20 MHz clock, synchronous reset.
//
// Contract
// - Trim byte bit 7: first edge sign
// - Bits 6:4: first edge magnitude, 5 ns steps
// - Bits 3, 2:0: second edge sign, magnitude
// - Resonant mode: fixed duty, varying period
// - Drives A, B only in first half
// - Drives C, D only in second half
// - Bits 5:0 frequency field; all-ones means resonant
// - Edges delayed from cycle start, 5 ns units
//
// Register access over AXI4-Lite was left to the implementer.
`include "resonant_pwm_defines.svh"
`default_nettype none
module resonant_pwm_edge_timing
  import resonant_pwm_pkg::*;
#(
  parameter int unsigned CW = 16
)(
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [11:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [11:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic             drive_a_o,
  output logic             drive_b_o,
  output logic             drive_c_o,
  output logic             drive_d_o,
  output logic             resonant_active_o
);

  localparam logic [CW-1:0] TPC = CW'(`TICKS_PER_CLK);

  // Byte address of a register index
  function automatic logic [11:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction

  // Nominal edge moved by a trim; negative saturates at the cycle start
  function automatic logic [CW-1:0] trim_edge(input logic [CW-1:0] nom,
                                              input edge_trim_t t);
    logic [CW-1:0] m;
    m = {{(CW-3){1'b0}}, t.mag};
    if (t.neg)
      trim_edge = (nom > m) ? nom - m : '0;
    else
      trim_edge = nom + m;
  endfunction

  logic [7:0]    sw_freq_q;
  logic [7:0]    edge_trim7_q;
  logic [CW-1:0] period_q;
  logic [CW-1:0] dead_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          awready_q;
  logic          wready_q;
  logic          bvalid_q;
  logic [1:0]    bresp_q;
  logic          arready_q;
  logic          rvalid_q;
  logic [1:0]    rresp_q;
  logic [31:0]   rdata_q;
  logic          drv_a_q;
  logic          drv_b_q;
  logic          drv_c_q;
  logic          drv_d_q;
  logic          res_q;

  // Bus decode
  wire wr_hs   = awready_q & s_axi_awvalid_i & s_axi_wvalid_i;
  wire rd_hs   = arready_q & s_axi_arvalid_i;
  wire wr_freq = wr_hs & (s_axi_awaddr_i == byte_addr(`SW_FREQ_IDX));
  wire wr_trim = wr_hs & (s_axi_awaddr_i == byte_addr(`EDGE_TRIM7_IDX));
  wire wr_per  = wr_hs & (s_axi_awaddr_i == byte_addr(`PERIOD_IDX));
  wire wr_dead = wr_hs & (s_axi_awaddr_i == byte_addr(`DEAD_IDX));
  wire wr_hit  = wr_freq | wr_trim | wr_per | wr_dead;

  // Mode and trim field decode
  wire        resonant_w = (sw_freq_q[`FREQ_FIELD_MSB:0] == `RESONANT_CODE);
  edge_trim_t trim1_w;
  edge_trim_t trim2_w;
  assign trim1_w = {edge_trim7_q[`TRIM1_SIGN_BIT],
                    edge_trim7_q[`TRIM1_MAG_LSB +: 3]};
  assign trim2_w = {edge_trim7_q[`TRIM2_SIGN_BIT],
                    edge_trim7_q[`TRIM2_MAG_LSB +: 3]};

  // Cycle timing in 5 ns ticks; the counter steps ten ticks per clock, so
  // edges land on the first clock at or past their tick (50 ns granularity)
  wire [CW-1:0] mid_w    = period_q >> 1;
  wire [CW-1:0] cnt_nx_w = cnt_q + TPC;
  wire          wrap_w   = cnt_nx_w >= period_q;
  half_t        half_w;
  assign half_w   = (cnt_q < mid_w) ? HALF_FIRST : HALF_SECOND;
  assign cnt_d    = (!resonant_w || wrap_w) ? '0 : cnt_nx_w;
  wire [CW-1:0] edge_a_w = trim_edge(dead_q, trim1_w);
  wire [CW-1:0] edge_c_w = mid_w + trim_edge(dead_q, trim2_w);
  wire [CW-1:0] edge_d_w = mid_w + dead_q;
  wire first_w  = resonant_w && (half_w == HALF_FIRST);
  wire second_w = resonant_w && (half_w == HALF_SECOND);
  wire a_w = first_w  && (cnt_q >= edge_a_w);
  wire b_w = first_w  && (cnt_q >= dead_q);
  wire c_w = second_w && (cnt_q >= edge_c_w);
  wire d_w = second_w && (cnt_q >= edge_d_w);

  // Read mux; unmapped reads answer zero with SLVERR
  wire [11:0] ra = s_axi_araddr_i;
  wire        rd_hit = (ra == byte_addr(`SW_FREQ_IDX)) || (ra == byte_addr(`EDGE_TRIM7_IDX))
                    || (ra == byte_addr(`PERIOD_IDX)) || (ra == byte_addr(`DEAD_IDX))
                    || (ra == byte_addr(`STATUS_IDX));
  wire [31:0] rd_w =
      (ra == byte_addr(`SW_FREQ_IDX))    ? {24'h00_0000, sw_freq_q} :
      (ra == byte_addr(`EDGE_TRIM7_IDX)) ? {24'h00_0000, edge_trim7_q} :
      (ra == byte_addr(`PERIOD_IDX))     ? {{(32-CW){1'b0}}, period_q} :
      (ra == byte_addr(`DEAD_IDX))       ? {{(32-CW){1'b0}}, dead_q} :
      (ra == byte_addr(`STATUS_IDX))     ? {14'h0000, res_q, half_w, cnt_q} :
                                           32'h0000_0000;

  // Write channel: ready one cycle after both valids, response after
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
    end
    else
    begin
      awready_q <= s_axi_awvalid_i & s_axi_wvalid_i & ~awready_q & ~bvalid_q;
      wready_q  <= s_axi_awvalid_i & s_axi_wvalid_i & ~awready_q & ~bvalid_q;
      if (wr_hs)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready_i)
        bvalid_q <= 1'b0;
    end
  end

  // Register file; byte lane 0 carries the 8-bit registers
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      sw_freq_q    <= `SW_FREQ_RST;
      edge_trim7_q <= `EDGE_TRIM7_RST;
      period_q     <= `PERIOD_RST;
      dead_q       <= `DEAD_RST;
    end
    else
    begin
      if (wr_freq && s_axi_wstrb_i[0])
        sw_freq_q <= s_axi_wdata_i[7:0];
      if (wr_trim && s_axi_wstrb_i[0])
        edge_trim7_q <= s_axi_wdata_i[7:0];
      if (wr_per && (s_axi_wstrb_i[1:0] == 2'b11))
        period_q <= s_axi_wdata_i[CW-1:0];
      if (wr_dead && (s_axi_wstrb_i[1:0] == 2'b11))
        dead_q <= s_axi_wdata_i[CW-1:0];
    end
  end

  // Read channel
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= `RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      arready_q <= s_axi_arvalid_i & ~arready_q & ~rvalid_q;
      if (rd_hs)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_w;
        rresp_q  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rready_i)
        rvalid_q <= 1'b0;
    end
  end

  // Cycle counter and registered drives; outputs lag the counter one clock
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q   <= '0;
      drv_a_q <= 1'b0;
      drv_b_q <= 1'b0;
      drv_c_q <= 1'b0;
      drv_d_q <= 1'b0;
      res_q   <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      drv_a_q <= a_w;
      drv_b_q <= b_w;
      drv_c_q <= c_w;
      drv_d_q <= d_w;
      res_q   <= resonant_w;
    end
  end

  assign s_axi_awready_o   = awready_q;
  assign s_axi_wready_o    = wready_q;
  assign s_axi_bvalid_o    = bvalid_q;
  assign s_axi_bresp_o     = bresp_q;
  assign s_axi_arready_o   = arready_q;
  assign s_axi_rvalid_o    = rvalid_q;
  assign s_axi_rresp_o     = rresp_q;
  assign s_axi_rdata_o     = rdata_q;
  assign drive_a_o         = drv_a_q;
  assign drive_b_o         = drv_b_q;
  assign drive_c_o         = drv_c_q;
  assign drive_d_o         = drv_d_q;
  assign resonant_active_o = res_q;

  // Checks on the timing core
  property p_first_half;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (drive_a_o || drive_b_o) |-> $past(cnt_q) < $past(mid_w);
  endproperty
  a_first_half: assert property (p_first_half) else $error("A/B high outside first half");

  property p_second_half;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (drive_c_o || drive_d_o) |-> $past(cnt_q) >= $past(mid_w);
  endproperty
  a_second_half: assert property (p_second_half) else $error("C/D high outside second half");

  property p_mode_off;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      !resonant_w [*2] |-> !(drive_a_o || drive_b_o || drive_c_o || drive_d_o);
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("Drive active outside resonant mode");

  property p_mode_code;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (sw_freq_q[5:0] == 6'h3F) |=> resonant_active_o;
  endproperty
  a_mode_code: assert property (p_mode_code) else $error("Code 0x3F did not select resonant");

  property p_trim1_pos;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      !edge_trim7_q[7] |-> edge_a_w == dead_q + CW'(edge_trim7_q[6:4]);
  endproperty
  a_trim1_pos: assert property (p_trim1_pos) else $error("First edge positive trim wrong");

  property p_trim1_neg;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (edge_trim7_q[7] && dead_q > CW'(edge_trim7_q[6:4]))
        |-> edge_a_w == dead_q - CW'(edge_trim7_q[6:4]);
  endproperty
  a_trim1_neg: assert property (p_trim1_neg) else $error("First edge negative trim wrong");

  property p_trim2;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      !edge_trim7_q[3] |-> edge_c_w == mid_w + dead_q + CW'(edge_trim7_q[2:0]);
  endproperty
  a_trim2: assert property (p_trim2) else $error("Second edge trim wrong");

  property p_tick_step;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (resonant_w && cnt_q != '0) |-> cnt_q == $past(cnt_q) + TPC;
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("Counter did not step ten ticks");

  property p_early_edge;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      ($past(edge_trim7_q[7]) && $rose(drive_b_o)) |-> drive_a_o;
  endproperty
  a_early_edge: assert property (p_early_edge) else $error("Negative trim not earlier");

endmodule
`default_nettype wire

// ---- gate_stage_model.sv ----
// Behavioural model of the gate drivers on the resonant bridge.
// Assumes registered, active-high drive levels on the one core clock.
`default_nettype none
module gate_stage_model
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic a_i,
  input  wire logic b_i,
  input  wire logic c_i,
  input  wire logic d_i,
  output logic      overlap_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both legs on at once would short the bridge, so latch it for the bench
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      overlap_o <= 1'b0;
    else if ((a_i || b_i) && (c_i || d_i))
      overlap_o <= 1'b1;
  end
endmodule
`default_nettype wire

// ---- resonant_pwm_edge_timing_test.sv ----
// Self-checking bench for the resonant PWM edge timing block.
// Assumes the design, its package, defines header and the gate model.
`include "resonant_pwm_defines.svh"
`default_nettype none
module resonant_pwm_edge_timing_test;
  timeunit 1ns;
  timeprecision 1ps;
  import resonant_pwm_pkg::*;
  localparam logic [11:0] A_FREQ = {2'b00, `SW_FREQ_IDX, 2'b00};
  localparam logic [11:0] A_TRIM = {2'b00, `EDGE_TRIM7_IDX, 2'b00};
  localparam logic [11:0] A_PER  = {2'b00, `PERIOD_IDX, 2'b00};
  localparam logic [11:0] A_DEAD = {2'b00, `DEAD_IDX, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, `STATUS_IDX, 2'b00};
  logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0;
  logic        arv = 1'b0, rre = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0000_0000;
  logic [7:0]  rnd = 8'h05;
  logic        awr, wr_rdy, bv, arr, rv, a, b, c, d, res, ovl;
  logic [1:0]  br, rr;
  logic [31:0] rd;
  logic [33:0] exp_q[$];
  int          n_fail = 0, n_tests = 0, cyc = 0, fa, fb, fc, fd, pr, wb;

  resonant_pwm_edge_timing #(.CW(16)) DUT (.ref_clk_i(clk), .sys_rst_i(rst),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_rdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .drive_a_o(a), .drive_b_o(b),
    .drive_c_o(c), .drive_d_o(d), .resonant_active_o(res));
  gate_stage_model gates (.clk_i(clk), .rst_i(rst), .a_i(a), .b_i(b), .c_i(c),
    .d_i(d), .overlap_o(ovl));

  initial
  begin
    forever #25 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Clock on which a count of 5 ns ticks is first reached, ten ticks a clock
  function automatic int ck(input int e);
    return (e + 9) / 10;
  endfunction
  // Negative trims move earlier and stop at the cycle start
  function automatic int trm(input int dt, input logic neg, input logic [2:0] m);
    return neg ? ((dt > m) ? dt - m : 0) : dt + m;
  endfunction

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    n_tests++;
    if (seen !== want)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, want);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Address and data go up together and drop each as it is taken
  task automatic wr(input logic [11:0] ad, input logic [31:0] dv,
                    input logic [1:0] r = `RESP_OKAY);
    exp_q.push_back({r, 32'h0000_0000});
    awa <= ad; wd <= dv; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    // Only the bench timeout ends a wait, so a lost answer counts as a fail
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end
    while (!bv);
    bre <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input logic [11:0] ad, input logic [31:0] dv,
                     input logic [1:0] r = `RESP_OKAY);
    exp_q.push_back({r, dv});
    ara <= ad; arv <= 1'b1; rre <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end
    while (!rv);
    rre <= 1'b0;
    @(posedge clk);
  endtask

  // Edge indices counted from the clock where drive D has just dropped
  task automatic measure;
    logic p;
    p = 1'b0; fa = -1; fb = -1; fc = -1; fd = -1; pr = -1; wb = 0;
    for (int i = 0; i < 200 && !(p && !d); i++)
    begin
      p = d;
      @(posedge clk);
    end
    for (int i = 0; i < 60; i++)
    begin
      if (a && fa < 0) fa = i;
      if (b && fb < 0) fb = i;
      if (c && fc < 0) fc = i;
      if (d && fd < 0) fd = i;
      wb += b;
      if (i > 0 && p && !d)
      begin
        pr = i;
        break;
      end
      p = d;
      @(posedge clk);
    end
  endtask

  // Answers are compared in arrival order against the noted expectations
  always @(posedge clk)
  begin
    if ((bv && bre) || (rv && rre))
      check(bv ? {br, 32'h0000_0000} : {rr, rd}, exp_q.pop_front());
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      test_done();
    end
  end

  initial
  begin
    int per, dt, ea, ec, mid;
    logic [7:0] fv [3];
    fv = '{8'h3E, 8'hFF, 8'h3F};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(A_FREQ, 32'h0000_0000);
    rdc(A_TRIM, 32'h0000_0000);
    rdc(A_PER, 32'h0000_00C8);
    rdc(A_DEAD, 32'h0000_000A);
    rdc(12'h0FC, 32'h0000_0000, `RESP_SLVERR);
    wr(12'h0FC, 32'h0000_00FF, `RESP_SLVERR);
    wr(A_STAT, 32'h0000_0001, `RESP_SLVERR);
    rdc(A_STAT, 32'h0000_0000);
    foreach (fv[i])
    begin
      wr(A_FREQ, {24'h00_0000, fv[i]});
      rdc(A_FREQ, {24'h00_0000, fv[i]});
      repeat (3) @(posedge clk);
      check({33'h0, res}, {33'h0, fv[i][5:0] == 6'h3F});
      if (i == 0) check({30'h0, a, b, c, d}, 34'h0);
    end
    for (int k = 0; k < 6; k++)
    begin
      per = k[0] ? 160 : 200;
      dt = k[0] ? 13 : 10;
      rnd = lfsr(rnd);
      wr(A_PER, per);
      wr(A_DEAD, dt);
      wr(A_TRIM, {24'h00_0000, rnd});
      rdc(A_TRIM, {24'h00_0000, rnd});
      measure();
      measure();
      ea = trm(dt, rnd[7], rnd[6:4]);
      ec = trm(dt, rnd[3], rnd[2:0]);
      mid = per / 2;
      check(34'(fa - fb), 34'(ck(ea) - ck(dt)));
      check(34'(fc - fd), 34'(ck(mid + ec) - ck(mid + dt)));
      check(34'(fd - fb), 34'(ck(mid + dt) - ck(dt)));
      check(34'(pr), 34'(ck(per)));
      check(34'(wb), 34'(ck(mid) - ck(dt)));
    end
    wr(A_FREQ, 32'h0000_0000);
    repeat (3) @(posedge clk);
    check({29'h0, res, a, b, c, d}, 34'h0);
    check({33'h0, ovl}, 34'h0);
    test_done();
  end
endmodule
`default_nettype wire
